// file: verilog/spcd_regs.svh
// What this block does
// - enable cleared in splitter mode stops clock
// - settings ignored while splitter mode off
// - select: half pixel, phy, ref zero, ref one
// - splitter select overrides the legacy selection
// - bits 4:0 of control low hold M
// - divisor register holds eight-bit N
// - reset: enabled, select 00, M 1, N 2
// - each output port keeps own settings copy
`ifndef SPCD_REGS_SVH
`define SPCD_REGS_SVH

// register indices, byte address is four times the index
`define SPCD_IDX_CTL_LOW     10'h03e
`define SPCD_IDX_DIVISOR     10'h03f
`define SPCD_IDX_MODE        10'h060
`define SPCD_IDX_STATUS      10'h061

// control low field positions
`define SPCD_EN_BIT          7
`define SPCD_SEL_HI          6
`define SPCD_SEL_LO          5
`define SPCD_M_HI            4
`define SPCD_M_LO            0

// mode register field positions
`define SPCD_MODE_SPLIT_BIT  0
`define SPCD_MODE_PORT_BIT   1

// reset values
`define SPCD_CTL_LOW_RST     8'h81
`define SPCD_DIVISOR_RST     8'h02
`define SPCD_MODE_RST        2'h0

// geometry
`define SPCD_PORTS           2
`define SPCD_SOURCES         4
`define SPCD_ADDR_W          12
`define SPCD_ACC_W           9

`endif

// file: verilog/spcd_pkg.sv
`default_nettype none
package spcd_pkg;
    // splitter transmit clock source
    typedef enum logic [1:0] {
        spcd_src_half_pixel = 2'b00,
        spcd_src_phy_mn     = 2'b01,
        spcd_src_ref0_mn    = 2'b10,
        spcd_src_ref1_mn    = 2'b11
    } spcd_src_t;

    // order of the raw source lines into the edge detector
    typedef enum logic [1:0] {
        spcd_line_pixel = 2'b00,
        spcd_line_phy   = 2'b01,
        spcd_line_ref0  = 2'b10,
        spcd_line_ref1  = 2'b11
    } spcd_line_t;
endpackage
`default_nettype wire

// file: verilog/spcd_src_edges.sv
`timescale 1ns/100ps
`default_nettype none
`include "spcd_regs.svh"
module spcd_src_edges
    import spcd_pkg::*;
(
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // sampled source clock levels
    input  wire logic [`SPCD_SOURCES-1:0]  src_level,
    // one-cycle pulse per source rising edge
    output logic      [`SPCD_SOURCES-1:0]  src_rise
);
    logic [`SPCD_SOURCES-1:0] prev_level;      // last sampled level
    logic [`SPCD_SOURCES-1:0] next_prev_level; // next sample
    logic [`SPCD_SOURCES-1:0] next_src_rise;   // next edge pulses

    ////////////////////////////////////////////////////////////////////////
    // per-source edge compare; sources must stay below half of pclk
    genvar gi;
    generate
        for (gi = 0; gi < `SPCD_SOURCES; gi = gi + 1) begin : g_src
            always_comb begin
                next_prev_level[gi] = src_level[gi];
                next_src_rise[gi]   = src_level[gi] & ~prev_level[gi];
            end
        end
    endgenerate

    // register levels and pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_level <= '0;
            src_rise   <= '0;
        end else begin
            prev_level <= next_prev_level;
            src_rise   <= next_src_rise;
        end
    end
endmodule
`default_nettype wire

// file: verilog/spcd_mn_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "spcd_regs.svh"
module spcd_mn_divider
    import spcd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        run,
    input  wire logic [4:0]  div_m,
    input  wire logic [7:0]  div_n,
    // source edge in, generated clock edge out
    input  wire logic        src_tick,
    output logic             out_tick
);
    logic [`SPCD_ACC_W-1:0] acc;           // phase accumulator
    logic [`SPCD_ACC_W-1:0] next_acc;      // next phase
    logic                   next_out_tick; // next output edge
    logic [`SPCD_ACC_W-1:0] sum;           // phase plus M

    ////////////////////////////////////////////////////////////////////////
    // fractional step: add M per source edge, emit on overflow and drop N, or clear the phase if N or more would remain
    always_comb begin
        sum           = acc + {4'h0, div_m};
        next_acc      = acc;
        next_out_tick = 1'b0;
        if (!run) begin
            // stopped divider restarts from zero phase
            next_acc = '0;
        end else if (src_tick) begin
            if (div_n == 8'h00) begin
                // N of zero has no meaning, pass source through
                next_out_tick = 1'b1;
                next_acc      = '0;
            end else if (sum >= {1'b0, div_n}) begin
                next_out_tick = 1'b1;
                next_acc      = (sum - {1'b0, div_n} >= {1'b0, div_n}) ? '0 : sum - {1'b0, div_n};
            end else begin
                next_acc = sum;
            end
        end
    end

    // register phase and edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc      <= '0;
            out_tick <= 1'b0;
        end else begin
            acc      <= next_acc;
            out_tick <= next_out_tick;
        end
    end
endmodule
`default_nettype wire

// file: verilog/spcd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "spcd_regs.svh"
module spcd_top
    import spcd_pkg::*;
(
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`SPCD_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // source clock levels
    input  wire logic                     pixel_clk_in,
    input  wire logic                     serial_video_phy_clk,
    input  wire logic                     external_reference_zero,
    input  wire logic                     external_reference_one,
    // selection from the separate clock configuration register
    input  wire logic [1:0]               legacy_clk_sel,
    // per-port transmit clock edges
    output logic      [`SPCD_PORTS-1:0]   tx_clk_tick
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]  ctl_low      [`SPCD_PORTS];  // per-port control low copy
    logic [7:0]  divisor      [`SPCD_PORTS];  // per-port N copy
    logic [7:0]  next_ctl_low [`SPCD_PORTS];  // next control low
    logic [7:0]  next_divisor [`SPCD_PORTS];  // next N
    logic        split_mode;                  // splitter mode enabled
    logic        port_sel;                    // port under register access
    logic        next_split_mode;             // next mode bit
    logic        next_port_sel;               // next port select
    logic [31:0] next_prdata;                 // next read data
    logic [`SPCD_SOURCES-1:0] src_rise;       // source edge pulses
    logic        half_phase;                  // pixel edge parity
    logic        next_half_phase;             // next parity
    logic        half_tick;                   // every second pixel edge
    logic [`SPCD_PORTS-1:0] mn_tick;          // M/N divider edges
    logic [`SPCD_PORTS-1:0] mn_run;           // M/N divider running
    logic [`SPCD_PORTS-1:0] mn_src;           // edge feeding each divider
    logic [`SPCD_PORTS-1:0] next_tx_clk_tick; // next output edges
    logic        wr_en;                       // write commits this edge
    logic        setup;                       // setup phase of a transfer
    logic [9:0]  idx;                         // register index
    logic        hit_low;                     // decode control low
    logic        hit_div;                     // decode divisor
    logic        hit_mode;                    // decode mode
    logic        hit_stat;                    // decode status
    logic        mapped;                      // any register hit

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so pready is simply high
    always_comb begin
        pready   = 1'b1;
        idx      = paddr[`SPCD_ADDR_W-1:2];
        hit_low  = 1'b0;
        hit_div  = 1'b0;
        hit_mode = 1'b0;
        hit_stat = 1'b0;
        if (idx == `SPCD_IDX_CTL_LOW) begin
            hit_low = 1'b1;
        end else if (idx == `SPCD_IDX_DIVISOR) begin
            hit_div = 1'b1;
        end else if (idx == `SPCD_IDX_MODE) begin
            hit_mode = 1'b1;
        end else if (idx == `SPCD_IDX_STATUS) begin
            hit_stat = 1'b1;
        end
        mapped  = hit_low | hit_div | hit_mode | hit_stat;
        // unmapped access ends with an error, writes to status too
        pslverr = psel & penable & (~mapped | (pwrite & hit_stat));
        setup   = psel & ~penable;
        wr_en   = psel & penable & pwrite & mapped & ~hit_stat;
    end

    ////////////////////////////////////////////////////////////////////////
    // register next values
    always_comb begin
        next_split_mode = split_mode;
        next_port_sel   = port_sel;
        for (int p = 0; p < `SPCD_PORTS; p++) begin
            next_ctl_low[p] = ctl_low[p];
            next_divisor[p] = divisor[p];
        end
        if (wr_en) begin
            if (hit_low) begin
                next_ctl_low[port_sel] = pwdata[7:0];
            end else if (hit_div) begin
                next_divisor[port_sel] = pwdata[7:0];
            end else if (hit_mode) begin
                next_split_mode = pwdata[`SPCD_MODE_SPLIT_BIT];
                next_port_sel   = pwdata[`SPCD_MODE_PORT_BIT];
            end
        end
    end

    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_mode <= 1'b0;
            port_sel   <= 1'b0;
            for (int p = 0; p < `SPCD_PORTS; p++) begin
                // enabled, half pixel, M 1, N 2
                ctl_low[p] <= `SPCD_CTL_LOW_RST;
                divisor[p] <= `SPCD_DIVISOR_RST;
            end
        end else begin
            split_mode <= next_split_mode;
            port_sel   <= next_port_sel;
            for (int p = 0; p < `SPCD_PORTS; p++) begin
                ctl_low[p] <= next_ctl_low[p];
                divisor[p] <= next_divisor[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in setup so it stands through the access phase
    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (hit_low) begin
                next_prdata[7:0] = ctl_low[port_sel];
            end else if (hit_div) begin
                next_prdata[7:0] = divisor[port_sel];
            end else if (hit_mode) begin
                next_prdata[`SPCD_MODE_SPLIT_BIT] = split_mode;
                next_prdata[`SPCD_MODE_PORT_BIT]  = port_sel;
            end else if (hit_stat) begin
                // live per-port divider running flags
                next_prdata[`SPCD_PORTS-1:0] = mn_run;
            end
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source edges
    spcd_src_edges u_edges (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_level ({external_reference_one, external_reference_zero,
                     serial_video_phy_clk, pixel_clk_in}),
        .src_rise  (src_rise)
    );

    // pixel clock halving by edge parity
    always_comb begin
        next_half_phase = half_phase ^ src_rise[spcd_line_pixel];
        half_tick       = src_rise[spcd_line_pixel] & half_phase;
    end

    // parity register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= next_half_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-port clock generation
    genvar gp;
    generate
        for (gp = 0; gp < `SPCD_PORTS; gp = gp + 1) begin : g_port
            always_comb begin
                case (spcd_src_t'(ctl_low[gp][`SPCD_SEL_HI:`SPCD_SEL_LO]))
                    spcd_src_phy_mn:  mn_src[gp] = src_rise[spcd_line_phy];
                    spcd_src_ref0_mn: mn_src[gp] = src_rise[spcd_line_ref0];
                    spcd_src_ref1_mn: mn_src[gp] = src_rise[spcd_line_ref1];
                    default:          mn_src[gp] = 1'b0;
                endcase
                mn_run[gp] = split_mode & ctl_low[gp][`SPCD_EN_BIT]
                           & (ctl_low[gp][`SPCD_SEL_HI:`SPCD_SEL_LO] != spcd_src_half_pixel);
            end

            spcd_mn_divider u_div (
                .pclk     (pclk),
                .presetn  (presetn),
                .run      (mn_run[gp]),
                .div_m    (ctl_low[gp][`SPCD_M_HI:`SPCD_M_LO]),
                .div_n    (divisor[gp]),
                .src_tick (mn_src[gp]),
                .out_tick (mn_tick[gp])
            );

            // output edge selection
            always_comb begin
                if (split_mode) begin
                    if (!ctl_low[gp][`SPCD_EN_BIT]) begin
                        next_tx_clk_tick[gp] = 1'b0;
                    end else if (ctl_low[gp][`SPCD_SEL_HI:`SPCD_SEL_LO] == spcd_src_half_pixel) begin
                        next_tx_clk_tick[gp] = half_tick;
                    end else begin
                        next_tx_clk_tick[gp] = mn_tick[gp];
                    end
                end else begin
                    next_tx_clk_tick[gp] = src_rise[legacy_clk_sel];
                end
            end
        end
    endgenerate

    // output edges from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_clk_tick <= '0;
        end else begin
            tx_clk_tick <= next_tx_clk_tick;
        end
    end
endmodule
`default_nettype wire

// file: verification/spcd_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "spcd_regs.svh"
module spcd_top_checker (
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`SPCD_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // sources and ticks
    input wire logic                    pixel_clk_in,
    input wire logic                    serial_video_phy_clk,
    input wire logic                    external_reference_zero,
    input wire logic                    external_reference_one,
    input wire logic [1:0]              legacy_clk_sel,
    input wire logic [`SPCD_PORTS-1:0]  tx_clk_tick
);
    ////////////////////////////////////////////////////////////////
    // decode of the transfer in flight
    wire logic [9:0] idx  = paddr[11:2];
    wire logic       hit  = idx inside {`SPCD_IDX_CTL_LOW, `SPCD_IDX_DIVISOR, `SPCD_IDX_MODE, `SPCD_IDX_STATUS};
    wire logic       stwr = pwrite && (idx == `SPCD_IDX_STATUS);
    wire logic [3:0] lvl  = {external_reference_one, external_reference_zero, serial_video_phy_clk, pixel_clk_in};
    logic [3:0]      lvl_q;      // last source levels
    logic [3:0]      hist;       // recent rises of any source
    logic [3:0]      next_lvl_q;
    logic [3:0]      next_hist;
    // history is generous: a tick needs some rise, not an exact one
    always_comb begin
        next_lvl_q = lvl;
        next_hist  = {hist[2:0], |(lvl & ~lvl_q)};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 4'h0;
            hist  <= 4'h0;
        end else begin
            lvl_q <= next_lvl_q;
            hist  <= next_hist;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_access: assert property (s_access |-> pready)
        else $error("pready low in access");
    a_err_unmapped: assert property (s_access and !hit |-> pslverr)
        else $error("no error on unmapped index");
    a_err_status_wr: assert property (s_access and stwr |-> pslverr)
        else $error("no error on status write");
    a_ok_mapped: assert property (s_access and hit && !stwr |-> !pslverr)
        else $error("error on mapped access");
    a_err_only_access: assert property (pslverr |-> s_access)
        else $error("error outside access");
    a_read_upper_zero: assert property (s_access and !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read upper bits set");
    a_read_unmapped_zero: assert property (s_access and !pwrite && !hit |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_holds: assert property (s_setup ##1 s_access |=> $stable(prdata))
        else $error("read data moved after access");
    a_tick_pulse: assert property ((tx_clk_tick & $past(tx_clk_tick)) == 2'h0)
        else $error("tick longer than one cycle");
    a_tick_cause: assert property (|tx_clk_tick |-> |hist)
        else $error("tick without a source edge");
endmodule
bind spcd_top spcd_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clk_in(pixel_clk_in), .serial_video_phy_clk(serial_video_phy_clk),
    .external_reference_zero(external_reference_zero), .external_reference_one(external_reference_one),
    .legacy_clk_sel(legacy_clk_sel), .tx_clk_tick(tx_clk_tick));
`default_nettype wire

// file: verification/spcd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module spcd_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  srcs = 4'h0;   // pixel, phy, ref zero, ref one
    logic [1:0]  lsel = 2'h0;   // legacy selection
    logic [1:0]  tick;
    logic [15:0] cnt [2];       // ticks seen per port
    logic [31:0] rd;
    logic        err;
    logic        split = 1'b0;  // model of splitter mode bit
    logic        counting = 1'b0;
    int          failures = 0;
    int          checked = 0;
    int          rises [4];
    int          m_en [2] = '{1, 1};
    int          m_sel [2] = '{0, 0};
    int          m_m [2] = '{1, 1};
    int          m_n [2] = '{2, 2};
    always #5 pclk = ~pclk;
    spcd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixel_clk_in(srcs[0]), .serial_video_phy_clk(srcs[1]), .external_reference_zero(srcs[2]),
        .external_reference_one(srcs[3]), .legacy_clk_sel(lsel), .tx_clk_tick(tick));
    // tick counters, cleared between windows
    always @(posedge pclk) begin
        for (int p = 0; p < 2; p++) cnt[p] <= counting ? cnt[p] + 16'(tick[p]) : 16'h0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // model: accumulate M per edge, tick when sum reaches N
    function automatic int mn(int r, int m, int nn);
        int a = 0;
        int t = 0;
        repeat (r) begin
            if (nn == 0) t++;
            else begin
                a += m;
                if (a >= nn) begin
                    t++;
                    a -= nn;
                end
            end
        end
        return t;
    endfunction
    // enable dropped first, settings, then enable; sources quiet meanwhile
    task automatic cfg(input int p, input logic en, input logic [1:0] s, input logic [4:0] m, input logic [7:0] nn);
        apb(1'b1, 12'h180, {30'h0, p[0], split});
        apb(1'b1, 12'h0f8, {24'h0, 1'b0, s, m});
        apb(1'b1, 12'h0fc, {24'h0, nn});
        apb(1'b1, 12'h0f8, {24'h0, en, s, m});
        apb(1'b0, 12'h0f8, 32'h0);
        `CHK(rd, {24'h0, en, s, m})
        apb(1'b0, 12'h0fc, 32'h0);
        `CHK(rd, {24'h0, nn})
        m_en[p] = en;
        m_sel[p] = s;
        m_m[p] = m;
        m_n[p] = nn;
    endtask
    // all four sources run at different rates, ticks counted per port
    task automatic window();
        int e;
        rises = '{default: 0};
        counting <= 1'b1;
        for (int c = 0; c < 120; c++) begin
            @(posedge pclk);
            for (int i = 0; i < 4; i++) begin
                if ((c / (i + 3)) % 2 == 1 && !srcs[i]) rises[i]++;
                srcs[i] <= ((c / (i + 3)) % 2 == 1);
            end
        end
        @(posedge pclk) srcs <= 4'h0;
        repeat (10) @(posedge pclk);
        for (int p = 0; p < 2; p++) begin
            if (!split) e = rises[lsel];
            else if (m_en[p] == 0) e = 0;
            else if (m_sel[p] == 0) e = rises[0] / 2;
            else e = mn(rises[m_sel[p]], m_m[p], m_n[p]);
            `CHK(cnt[p], 16'(e))
        end
        // let one edge clear the counters before the next window starts
        counting <= 1'b0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the expected run length
    initial begin
        #500000;
        failures++;
        conclude();
    end
    initial begin
        int m;
        int nn;
        m = $urandom(32'hb95cc664);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h180, 32'h0);
        `CHK(rd, 32'h0)
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h180, {30'h0, p[0], 1'b0});
            apb(1'b0, 12'h0f8, 32'h0);
            `CHK(rd, 32'h81)
            apb(1'b0, 12'h0fc, 32'h0);
            `CHK(rd, 32'h02)
        end
        // refused accesses
        apb(1'b0, 12'h000, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h184, 32'h3);
        `CHK(err, 1'b1)
        // defaults in splitter mode beat a legacy choice of ref zero
        split = 1'b1;
        lsel <= 2'h2;
        apb(1'b1, 12'h180, 32'h1);
        window();
        for (int s = 0; s < 4; s++) begin
            m = 1 + $urandom % 31;
            nn = m + $urandom % (256 - m);
            cfg(0, 1'b1, 2'(s), 5'(m), 8'(nn));
            cfg(1, 1'b1, 2'(s + 1), 5'(m + 1), 8'(nn + 1));
            window();
        end
        // port zero stopped, port one with M above N
        cfg(0, 1'b0, 2'h1, 5'h3, 8'h2);
        cfg(1, 1'b1, 2'h1, 5'h7, 8'h3);
        apb(1'b0, 12'h184, 32'h0);
        `CHK(rd, 32'h2)
        window();
        // splitter off: settings ignored, legacy source passes
        split = 1'b0;
        apb(1'b1, 12'h180, 32'h0);
        apb(1'b0, 12'h184, 32'h0);
        `CHK(rd, 32'h0)
        for (int l = 0; l < 4; l++) begin
            lsel <= 2'(l);
            window();
        end
        conclude();
    end
endmodule
`default_nettype wire
